/* File: dls_pkg.sv */
package dls_pkg;

  localparam int WORD_W = 8;
  localparam int SER_RATIO = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
  localparam int DELAY_W = 6;
  localparam logic [DELAY_W-1:0] DELAY_INIT = 6'h00;
  localparam int BUF_DEPTH = 2;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;

  // lane function picked by the fabric when the lane is built
  typedef enum logic [1:0] {
    DLS_MODE_CLK_RX,
    DLS_MODE_DATA_RX,
    DLS_MODE_TX
  } dls_mode_t;

  // one value per pad of the differential pair
  typedef struct packed {
    logic pos;
    logic neg;
  } dls_pair_t;

endpackage : dls_pkg

/* File: dls_word_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module dls_word_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("dls_word_buf: DEPTH must be at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic full_q;
  logic empty_q;

  wire push = ce && in_valid && !full_q;
  wire pop = ce && out_ready && !empty_q;

  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else if (ce) begin
      if (push) wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + PW'(1);
      if (pop) rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + PW'(1);
      cnt_q <= cnt_d;
      full_q <= (cnt_d == FULL_CNT);
      empty_q <= (cnt_d == '0);
    end
  end

endmodule : dls_word_buf
`default_nettype wire

/* File: dls_lane.sv */
// Behaviour
// - rx data lane hands the core eight-bit words timed by the parallel clock
// - low-power pad levels reach the core as two separate signals
// - with queue on, empty flag is high whenever the queue holds nothing
// - clock lane forwards divided and serial clocks for data lanes
// - receive reset clears queue and deserializer at once
// - inputs switch receive buffer and termination on for high-speed mode
// - while stepping enabled, delay counts up or down per parallel clock
// - delay clear returns the delay counter to its initial value
// - clock lane makes the clocks for its group plus a global clock
// - transmit reset, sampled on every enabled mclk cycle, clears the serializer
// - serialized output drives the pads only while high-speed drive enabled
// - low-power transmit drives each pad from own bit and own enable
// - transmit lane returns pad levels only when used as reversible
// - high-speed data passes an eight-to-one converter; low-power bypasses it
// - receive clock lane divides incoming clock to make parallel clock
`timescale 1ns/1ps
`default_nettype none

module dls_lane #(
  parameter int DELAY_BITS = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire dls_pkg::dls_mode_t lane_mode,
  input wire logic lane_reversible,
  input wire logic fifo_en,
  input wire dls_pkg::dls_pair_t pad_in,
  output dls_pkg::dls_pair_t pad_out,
  output dls_pkg::dls_pair_t pad_oe,
  output logic [7:0] hs_rx_word,
  output logic lp_pos_pad_in,
  output logic lp_neg_pad_in,
  input wire logic lp_pos_pad_out,
  input wire logic lp_neg_pad_out,
  input wire logic lp_pos_drive_en,
  input wire logic lp_neg_drive_en,
  output logic queue_empty,
  input wire logic queue_rd_en,
  output logic rx_overrun,
  output logic lane_par_clk_fwd,
  output logic lane_ser_clk_fwd,
  output logic core_div_clk,
  input wire logic rx_reset,
  input wire logic hs_rx_buf_en,
  input wire logic en_a,
  output logic hs_rx_buf_on,
  output logic en_a_on,
  input wire logic delay_step_en,
  input wire logic delay_step_dir,
  input wire logic delay_count_clear,
  output logic [DELAY_BITS-1:0] delay_tap,
  input wire logic [7:0] hs_tx_word,
  input wire logic tx_reset,
  input wire logic hs_drive_en
);
  import dls_pkg::*;

  initial begin
    if (DELAY_BITS < 1 || DELAY_BITS > DELAY_W) begin
      $error("dls_lane: DELAY_BITS out of range");
    end
  end

  // pad synchronisers; only the second stage is read
  dls_pair_t pad_s1_q;
  dls_pair_t pad_s2_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic [WORD_W-1:0] rx_word_q;
  logic push_q;
  logic [WORD_W-1:0] tx_sh_q;
  logic [WORD_W-1:0] hs_rx_word_q;
  logic lp_pos_q;
  logic lp_neg_q;
  logic par_q;
  logic ser_q;
  logic div_q;
  logic buf_on_q;
  logic term_on_q;
  logic overrun_q;
  logic [DELAY_BITS-1:0] delay_q;
  dls_pair_t pad_out_q;
  dls_pair_t pad_oe_q;

  wire rx_clear = reset || rx_reset;
  wire par_tick = (bit_cnt_q == CNT_LAST);
  wire is_clk = (lane_mode == DLS_MODE_CLK_RX);
  wire is_rx = (lane_mode == DLS_MODE_DATA_RX);
  wire is_tx = (lane_mode == DLS_MODE_TX);
  wire rx_bit = buf_on_q & pad_s2_q.pos;
  wire [WORD_W-1:0] rx_word_d = {rx_bit, rx_sh_q[WORD_W-1:1]};
  wire rx_capture = ce && par_tick && is_rx && buf_on_q;
  wire lp_return = !is_tx || lane_reversible;
  wire lp_may_drive = is_tx || lane_reversible;
  wire tx_bit = tx_sh_q[0];
  wire buf_in_ready;
  wire buf_out_valid;
  wire [WORD_W-1:0] buf_out_data;
  wire buf_pop = queue_rd_en && buf_out_valid;
  wire delay_at_max = (delay_q == {DELAY_BITS{1'b1}});
  wire delay_at_min = (delay_q == '0);
  wire [DELAY_BITS-1:0] delay_init = DELAY_INIT[DELAY_BITS-1:0];

  dls_word_buf #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .reset(rx_clear),
    .ce(ce),
    .in_data(rx_word_q),
    .in_valid(push_q && fifo_en),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(queue_rd_en)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_s1_q <= '0;
      pad_s2_q <= '0;
      bit_cnt_q <= CNT_RST;
    end else if (ce) begin
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
      bit_cnt_q <= bit_cnt_q + CNT_W'(1);
    end
  end

  // deserializer, cleared with the queue
  always_ff @(posedge mclk or posedge rx_clear) begin
    if (rx_clear) begin
      rx_sh_q <= WORD_RST;
      rx_word_q <= WORD_RST;
      push_q <= 1'b0;
      hs_rx_word_q <= WORD_RST;
      overrun_q <= 1'b0;
    end else if (ce) begin
      rx_sh_q <= rx_word_d;
      push_q <= rx_capture;
      overrun_q <= push_q && fifo_en && !buf_in_ready;
      if (rx_capture) rx_word_q <= rx_word_d;
      if (fifo_en && buf_pop) begin
        hs_rx_word_q <= buf_out_data;
      end else if (!fifo_en && rx_capture) begin
        hs_rx_word_q <= rx_word_d;
      end
    end
  end

  // serializer, loaded once per parallel period, lsb first
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_sh_q <= WORD_RST;
    end else if (ce) begin
      if (tx_reset) tx_sh_q <= WORD_RST;
      else if (par_tick) tx_sh_q <= hs_tx_word;
      else tx_sh_q <= {1'b0, tx_sh_q[WORD_W-1:1]};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lp_pos_q <= 1'b0;
      lp_neg_q <= 1'b0;
      buf_on_q <= 1'b0;
      term_on_q <= 1'b0;
    end else if (ce) begin
      lp_pos_q <= lp_return & pad_s2_q.pos;
      lp_neg_q <= lp_return & pad_s2_q.neg;
      buf_on_q <= hs_rx_buf_en;
      term_on_q <= en_a;
    end
  end

  // forwarded clocks, only on a receive clock lane
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      par_q <= 1'b0;
      ser_q <= 1'b0;
      div_q <= 1'b0;
    end else if (ce) begin
      par_q <= is_clk & bit_cnt_q[CNT_W-1];
      ser_q <= is_clk & ~ser_q;
      div_q <= is_clk & bit_cnt_q[CNT_W-1];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      delay_q <= DELAY_INIT[DELAY_BITS-1:0];
    end else if (ce && par_tick) begin
      if (delay_count_clear) begin
        delay_q <= delay_init;
      end else if (delay_step_en && delay_step_dir && !delay_at_max) begin
        delay_q <= delay_q + DELAY_BITS'(1);
      end else if (delay_step_en && !delay_step_dir && !delay_at_min) begin
        delay_q <= delay_q - DELAY_BITS'(1);
      end
    end
  end

  // pad drive: high-speed wins over low-power
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
    end else if (ce) begin
      if (is_tx && hs_drive_en) begin
        pad_out_q <= '{pos: tx_bit, neg: ~tx_bit};
        pad_oe_q <= '{pos: 1'b1, neg: 1'b1};
      end else begin
        pad_out_q <= '{pos: lp_pos_pad_out, neg: lp_neg_pad_out};
        pad_oe_q <= '{pos: lp_may_drive & lp_pos_drive_en,
                      neg: lp_may_drive & lp_neg_drive_en};
      end
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign hs_rx_word = hs_rx_word_q;
  assign lp_pos_pad_in = lp_pos_q;
  assign lp_neg_pad_in = lp_neg_q;
  assign queue_empty = !buf_out_valid;
  assign rx_overrun = overrun_q;
  assign lane_par_clk_fwd = par_q;
  assign lane_ser_clk_fwd = ser_q;
  assign core_div_clk = div_q;
  assign hs_rx_buf_on = buf_on_q;
  assign en_a_on = term_on_q;
  assign delay_tap = delay_q;

  AST_BYPASS_WORD: assert property (@(posedge mclk) disable iff (rx_clear)
    ce && rx_capture && !fifo_en |=> hs_rx_word == $past(rx_word_d))
    else $error("bypass word not presented");
  AST_LP_LEVEL: assert property (@(posedge mclk) disable iff (reset)
    ce && !is_tx |=> lp_neg_pad_in == $past(pad_s2_q.neg))
    else $error("lp level not passed");
  AST_EMPTY_FLAG: assert property (@(posedge mclk) disable iff (rx_clear)
    ce && push_q && fifo_en && !queue_rd_en |=> !queue_empty)
    else $error("empty flag stuck after push");
  AST_SER_TOGGLE: assert property (@(posedge mclk) disable iff (reset)
    ce && is_clk && $past(ce) && $past(is_clk) |=> lane_ser_clk_fwd != $past(lane_ser_clk_fwd))
    else $error("serial clock forward not toggling");
  AST_RX_CLEAR: assert property (@(posedge mclk)
    rx_reset |=> queue_empty && hs_rx_word == WORD_RST)
    else $error("receive reset did not clear");
  AST_BUF_EN: assert property (@(posedge mclk) disable iff (reset)
    ce |=> hs_rx_buf_on == $past(hs_rx_buf_en) && en_a_on == $past(en_a))
    else $error("buffer or termination enable lost");
  AST_DELAY_STEP: assert property (@(posedge mclk) disable iff (reset)
    ce && par_tick && !delay_count_clear && delay_step_en && delay_step_dir
      && !delay_at_max |=> delay_tap == $past(delay_tap) + DELAY_BITS'(1))
    else $error("delay did not increment");
  AST_DELAY_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    ce && par_tick && delay_count_clear |=> delay_tap == delay_init)
    else $error("delay clear ignored");
  AST_TX_RESET: assert property (@(posedge mclk) disable iff (reset)
    ce && tx_reset |=> tx_sh_q == WORD_RST)
    else $error("serializer not reset");
  AST_HS_DRIVE: assert property (@(posedge mclk) disable iff (reset)
    ce && is_tx && !hs_drive_en && !lp_pos_drive_en |=> !pad_oe.pos)
    else $error("pad driven without enable");
  AST_LP_GUARD: assert property (@(posedge mclk) disable iff (reset)
    ce && !is_tx && !lane_reversible |=> pad_oe == '0)
    else $error("receive lane drove pads");
  AST_TX_RETURN: assert property (@(posedge mclk) disable iff (reset)
    ce && is_tx && !lane_reversible |=> !lp_pos_pad_in && !lp_neg_pad_in)
    else $error("tx lane returned lp level");

  COV_QUEUE_READ: cover property (@(posedge mclk) disable iff (rx_clear)
    fifo_en && buf_pop);
  COV_OVERRUN: cover property (@(posedge mclk) disable iff (rx_clear) rx_overrun);
  COV_HS_TX: cover property (@(posedge mclk) disable iff (reset)
    is_tx && hs_drive_en && par_tick);
  COV_DELAY_DOWN: cover property (@(posedge mclk) disable iff (reset)
    par_tick && delay_step_en && !delay_step_dir && !delay_at_min);

endmodule : dls_lane
`default_nettype wire

/* File: dls_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// remote endpoint: sends a repeating word lsb first as a differential pair,
// or holds low-power levels on both pads, and records the lane's hs output
module dls_far_end (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hs_on,
  input wire logic [7:0] word,
  input wire dls_pkg::dls_pair_t lp_lvl,
  input wire dls_pkg::dls_pair_t pad_out,
  input wire dls_pkg::dls_pair_t pad_oe,
  output var dls_pkg::dls_pair_t pad_in,
  output logic [7:0] seen,
  output logic pair_bad
);
  import dls_pkg::*;
  logic [2:0] bit_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bit_q <= 3'h0;
      pad_in <= 2'h3;
      seen <= 8'h00;
      pair_bad <= 1'b0;
    end else begin
      bit_q <= bit_q + 3'h1;
      pad_in <= hs_on ? {word[bit_q], ~word[bit_q]} : lp_lvl;
      seen <= {pad_out.pos, seen[7:1]};
      if (pad_oe == 2'h3 && pad_out.pos == pad_out.neg) begin
        pair_bad <= 1'b1;
      end
    end
  end
endmodule : dls_far_end

`default_nettype wire

/* File: dls_lane_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dls_lane_tb;
  import dls_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, ce = 1'b1, lane_reversible = 1'b0, fifo_en = 1'b0;
  dls_mode_t lane_mode = DLS_MODE_DATA_RX;
  dls_pair_t pad_in, pad_out, pad_oe;
  dls_pair_t lp_lvl = 2'h3;
  logic [7:0] hs_rx_word, seen, w;
  logic [7:0] hs_tx_word = 8'h00, rx_send = 8'h00;
  logic lp_pos_pad_in, lp_neg_pad_in, lp_pos_pad_out = 1'b0, lp_neg_pad_out = 1'b0;
  logic lp_pos_drive_en = 1'b0, lp_neg_drive_en = 1'b0, queue_rd_en = 1'b0, rx_reset = 1'b0;
  logic queue_empty, rx_overrun, lane_par_clk_fwd, lane_ser_clk_fwd, core_div_clk;
  logic hs_rx_buf_en = 1'b0, en_a = 1'b0, hs_rx_buf_on, en_a_on, pair_bad, pp, ps;
  logic delay_step_en = 1'b0, delay_step_dir = 1'b0, delay_count_clear = 1'b0;
  logic tx_reset = 1'b0, hs_drive_en = 1'b0, hs_on = 1'b0;
  logic [5:0] delay_tap;
  int n_errors = 0, checked = 0, n_ovr = 0, r = 0, na, nb, nc;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (rx_overrun === 1'b1) n_ovr++;

  dls_lane dut (.mclk(mclk), .reset(reset), .ce(ce), .lane_mode(lane_mode),
    .lane_reversible(lane_reversible), .fifo_en(fifo_en), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .hs_rx_word(hs_rx_word),
    .lp_pos_pad_in(lp_pos_pad_in), .lp_neg_pad_in(lp_neg_pad_in),
    .lp_pos_pad_out(lp_pos_pad_out), .lp_neg_pad_out(lp_neg_pad_out),
    .lp_pos_drive_en(lp_pos_drive_en), .lp_neg_drive_en(lp_neg_drive_en),
    .queue_empty(queue_empty), .queue_rd_en(queue_rd_en), .rx_overrun(rx_overrun),
    .lane_par_clk_fwd(lane_par_clk_fwd), .lane_ser_clk_fwd(lane_ser_clk_fwd),
    .core_div_clk(core_div_clk), .rx_reset(rx_reset), .hs_rx_buf_en(hs_rx_buf_en),
    .en_a(en_a), .hs_rx_buf_on(hs_rx_buf_on), .en_a_on(en_a_on),
    .delay_step_en(delay_step_en), .delay_step_dir(delay_step_dir),
    .delay_count_clear(delay_count_clear), .delay_tap(delay_tap),
    .hs_tx_word(hs_tx_word), .tx_reset(tx_reset), .hs_drive_en(hs_drive_en));

  dls_far_end far (.mclk(mclk), .reset(reset), .hs_on(hs_on), .word(rx_send),
    .lp_lvl(lp_lvl), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
    .seen(seen), .pair_bad(pair_bad));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task settle(input int n);
    cyc(n);
    @(negedge mclk);
  endtask : settle

  task restart(input dls_mode_t m);
    @(posedge mclk);
    reset <= 1'b1;
    lane_mode <= m;
    cyc(2);
    reset <= 1'b0;
  endtask : restart

  task end_sim;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // lane and far end both count from reset release, so words arrive rotated by a fixed amount
  function automatic logic [7:0] rotl(input logic [7:0] v, input int s);
    return (v << s) | (v >> (8 - s));
  endfunction : rotl

  function automatic int bitpos(input logic [7:0] v);
    for (int i = 0; i < 8; i++) if (v[i] === 1'b1) return i;
    return 0;
  endfunction : bitpos

  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    end_sim();
  end

  initial begin
    settle(15);
    chk(8'(queue_empty), 8'h01);
    chk(8'(delay_tap), 8'h00);
    chk(hs_rx_word, 8'h00);
    chk(8'(pad_oe), 8'h00);
    @(posedge mclk);
    reset <= 1'b0;
    hs_rx_buf_en <= 1'b1;
    en_a <= 1'b1;
    lp_lvl <= 2'h2;
    settle(6);
    chk(8'({hs_rx_buf_on, en_a_on}), 8'h03);
    chk(8'({lp_pos_pad_in, lp_neg_pad_in}), 8'h02);
    en_a <= 1'b0;
    lp_lvl <= 2'h1;
    settle(6);
    chk(8'({hs_rx_buf_on, en_a_on}), 8'h02);
    chk(8'({lp_pos_pad_in, lp_neg_pad_in}), 8'h01);
    lp_pos_pad_out <= 1'b1;
    lp_pos_drive_en <= 1'b1;
    lp_neg_drive_en <= 1'b1;
    settle(3);
    chk(8'(pad_oe), 8'h00);
    lane_reversible <= 1'b1;
    settle(3);
    chk(8'({pad_oe, pad_out}), 8'h0E);
    lane_reversible <= 1'b0;
    lp_pos_drive_en <= 1'b0;
    lp_neg_drive_en <= 1'b0;
    rx_send <= 8'h01;
    hs_on <= 1'b1;
    settle(24);
    r = bitpos(hs_rx_word);
    foreach (rx_send[i]) if (i < 2) begin
      w = i ? 8'hD2 : 8'h4B;
      rx_send <= w;
      settle(24);
      chk(hs_rx_word, rotl(w, r));
    end
    rx_send <= 8'h3C;
    // let the new word fill the pad pipeline so every queued word is whole
    settle(16);
    fifo_en <= 1'b1;
    settle(48);
    chk(8'(queue_empty), 8'h00);
    chk(8'(n_ovr != 0), 8'h01);
    hs_rx_buf_en <= 1'b0;
    cyc(16);
    queue_rd_en <= 1'b1;
    cyc(2);
    queue_rd_en <= 1'b0;
    settle(2);
    chk(hs_rx_word, rotl(8'h3C, r));
    chk(8'(queue_empty), 8'h01);
    hs_rx_buf_en <= 1'b1;
    cyc(24);
    hs_rx_buf_en <= 1'b0;
    cyc(4);
    rx_reset <= 1'b1;
    settle(1);
    chk(8'(queue_empty), 8'h01);
    chk(hs_rx_word, 8'h00);
    rx_reset <= 1'b0;
    settle(16);
    chk(8'(queue_empty), 8'h01);
    hs_on <= 1'b0;
    delay_step_en <= 1'b1;
    delay_step_dir <= 1'b1;
    settle(24);
    chk(8'(delay_tap), 8'h03);
    delay_step_dir <= 1'b0;
    settle(8);
    chk(8'(delay_tap), 8'h02);
    ce <= 1'b0;
    settle(16);
    chk(8'(delay_tap), 8'h02);
    ce <= 1'b1;
    delay_count_clear <= 1'b1;
    settle(8);
    chk(8'(delay_tap), 8'h00);
    delay_count_clear <= 1'b0;
    settle(8);
    chk(8'(delay_tap), 8'h00);
    delay_step_en <= 1'b0;
    restart(DLS_MODE_CLK_RX);
    settle(8);
    na = 0;
    nb = 0;
    nc = 0;
    pp = lane_par_clk_fwd;
    ps = lane_ser_clk_fwd;
    repeat (32) begin
      @(negedge mclk);
      if (lane_par_clk_fwd === 1'b1 && pp === 1'b0) na++;
      if (lane_ser_clk_fwd !== ps) nb++;
      if (core_div_clk !== lane_par_clk_fwd) nc++;
      pp = lane_par_clk_fwd;
      ps = lane_ser_clk_fwd;
    end
    chk(8'(na), 8'h04);
    chk(8'(nb), 8'h20);
    chk(8'(nc), 8'h00);
    restart(DLS_MODE_TX);
    hs_drive_en <= 1'b1;
    hs_tx_word <= 8'h01;
    settle(24);
    r = bitpos(seen);
    chk(8'(pad_oe), 8'h03);
    foreach (rx_send[i]) if (i < 2) begin
      w = i ? 8'hE1 : 8'h4B;
      hs_tx_word <= w;
      settle(24);
      chk(seen, rotl(w, r));
    end
    tx_reset <= 1'b1;
    settle(12);
    chk(seen, 8'h00);
    tx_reset <= 1'b0;
    chk(8'(pair_bad), 8'h00);
    hs_drive_en <= 1'b0;
    lp_pos_drive_en <= 1'b1;
    lp_lvl <= 2'h3;
    settle(3);
    chk(8'({pad_oe, pad_out.pos}), 8'h05);
    settle(3);
    chk(8'({lp_pos_pad_in, lp_neg_pad_in}), 8'h00);
    lane_reversible <= 1'b1;
    settle(5);
    chk(8'({lp_pos_pad_in, lp_neg_pad_in}), 8'h03);
    end_sim();
  end
endmodule : dls_lane_tb

`default_nettype wire
